// *** rtl/rsc_reset_control.v ***
// Functional notes
// - five reset inputs: pin, power-on, brown-out, software, watchdog.
// - power-on resets core, peripherals and test-access controller.
// - pin reset hits core and peripherals; test controller keeps its state.
// - brown-out, software system and watchdog resets spare the test controller.
// - peripheral software reset hits only the selected peripherals.
// - software system reset comes from the core request bit.
// - each completed reset sets the flag of its source.
// - cause flags are sticky until software clears them.
// - power-on clears all cause flags except the power-on flag, which it sets.
// - power-on holds reset until the detector drops, then starts fetch.
// - power-on detector only acts at initial power-up.
// - pin held for the minimum pulse; after release core starts fetch.
// - reset lasts as long as the pin is held low.
// - power-on, test reset or test-logic-reset load the identification instruction.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "rsc_defs.vh"
module rsc_reset_control #(
  parameter NUM_PERIPH = 8,
  parameter STRETCH    = `RSC_STRETCH_CYC
) (
  input  wire                  clock,
  input  wire                  arst_n,
  input  wire                  ext_reset_n,
  input  wire                  brownout_detect,
  input  wire                  sw_system_reset_request,
  input  wire                  watchdog_reset,
  input  wire                  test_reset_n,
  input  wire                  tap_logic_reset_state,
  input  wire                  test_mode_pin0,
  input  wire                  test_mode_pin1,
  input  wire [3:0]            reg_addr,
  input  wire [31:0]           reg_wdata,
  input  wire                  reg_write,
  input  wire                  reg_read,
  output reg  [31:0]           reg_rdata,
  output wire                  irq,
  output wire                  core_reset_n,
  output wire                  tap_reset_n,
  output wire                  tap_pin_cfg_reset_n,
  output wire [NUM_PERIPH-1:0] periph_reset_n,
  output wire                  fetch_start,
  output reg  [3:0]            tap_default_instr,
  output wire                  test_mode_error
);
  // arst_n is the power-on detector output; it only pulses at power-up
  reg        por_s1;
  reg        por_s2;
  reg        ext_s1;
  reg        ext_s2;
  reg        tap_rst_s1;
  reg        tap_rst_s2;
  reg [`RSC_CAUSE_W-1:0] cause;
  reg [`RSC_CAUSE_W-1:0] pending;
  reg [`RSC_CAUSE_W-1:0] mask;
  reg [`RSC_CAUSE_W-1:0] status;
  reg [NUM_PERIPH-1:0]   periph_sel;
  reg        bor_en;
  reg [1:0]  rel_state;
  reg [1:0]  next_rel_state;
  reg [7:0]  stretch;
  reg [7:0]  next_stretch;
  reg        fetch;
  reg        next_fetch;
  reg        por_pending;
  reg [`RSC_CAUSE_W-1:0]  next_cause;
  reg [`RSC_CAUSE_W-1:0]  next_status;
  reg [31:0] next_rdata;
  wire [`RSC_CAUSE_W-1:0] active;
  wire       any_active;
  wire       sys_rst;
  wire       sys_rst_n;
  wire       done;
  wire       rd_status;
  wire       wr_cause;
  wire       wr_periph;
  wire       wr_mask;
  wire       wr_ctrl;
  localparam [1:0] ST_RESET = 2'b00;
  localparam [1:0] ST_RUN   = 2'b01;
  localparam [`RSC_CAUSE_W-1:0] POR_ONLY = {{(`RSC_CAUSE_W-1){1'b0}}, 1'b1} << `RSC_CAUSE_POR;

  // two-flop release; assert is asynchronous through the reset pins
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      por_s1 <= 1'b0;
      por_s2 <= 1'b0;
    end else begin
      por_s1 <= 1'b1;
      por_s2 <= por_s1;
    end
  end

  wire ext_clr_n = arst_n & ext_reset_n;
  always @(posedge clock or negedge ext_clr_n) begin
    if (!ext_clr_n) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
    end else begin
      ext_s1 <= 1'b1;
      ext_s2 <= ext_s1;
    end
  end

  wire tap_clr_n = arst_n & test_reset_n;
  always @(posedge clock or negedge tap_clr_n) begin
    if (!tap_clr_n) begin
      tap_rst_s1 <= 1'b0;
      tap_rst_s2 <= 1'b0;
    end else begin
      tap_rst_s1 <= 1'b1;
      tap_rst_s2 <= tap_rst_s1;
    end
  end

  // all five sources merge; pin reset held as long as low
  assign active[`RSC_CAUSE_EXT] = ~ext_s2 & por_s2;
  assign active[`RSC_CAUSE_POR] = ~por_s2;
  assign active[`RSC_CAUSE_BOR] = brownout_detect & bor_en;
  assign active[`RSC_CAUSE_SW]  = sw_system_reset_request;
  assign active[`RSC_CAUSE_WDT] = watchdog_reset;
  assign any_active = |active;

  // release only when every source is gone plus a short stretch
  assign done = (rel_state == ST_RESET) && !any_active && (stretch == STRETCH[7:0] - 8'h01);
  always @* begin
    next_rel_state = rel_state;
    next_stretch   = stretch;
    next_fetch     = 1'b0;
    case (rel_state)
      ST_RESET: begin
        if (any_active) begin
          next_stretch = 8'h00;
        end else if (done) begin
          next_rel_state = ST_RUN;
          next_fetch     = 1'b1;
        end else begin
          next_stretch = stretch + 8'h01;
        end
      end
      ST_RUN: begin
        // a new source restarts the stretch from zero
        if (any_active) begin
          next_rel_state = ST_RESET;
          next_stretch   = 8'h00;
        end
      end
      default: begin
        next_rel_state = ST_RESET;
        next_stretch   = 8'h00;
      end
    endcase
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rel_state <= ST_RESET;
      stretch   <= 8'h00;
      fetch     <= 1'b0;
      pending   <= {`RSC_CAUSE_W{1'b0}};
    end else begin
      rel_state <= next_rel_state;
      stretch   <= next_stretch;
      fetch     <= next_fetch;
      if (any_active) begin
        pending <= pending | active;
      end else if (done) begin
        pending <= {`RSC_CAUSE_W{1'b0}};
      end
    end
  end
  assign sys_rst     = (rel_state != ST_RUN);
  assign sys_rst_n   = ~sys_rst;
  assign fetch_start = fetch;

  // domain fan-out
  assign core_reset_n        = sys_rst_n;
  assign tap_reset_n         = por_s2 & tap_rst_s2;
  assign tap_pin_cfg_reset_n = por_s2 & ext_s2;
  // one gate per peripheral; a select bit holds only its own peripheral
  genvar g;
  generate
    for (g = 0; g < NUM_PERIPH; g = g + 1) begin : g_periph
      assign periph_reset_n[g] = sys_rst_n & ~periph_sel[g];
    end
  endgenerate


  // default test instruction reloads on any test reset path
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tap_default_instr <= `RSC_ID_INSTR;
    end else if (!tap_rst_s2 || tap_logic_reset_state) begin
      tap_default_instr <= `RSC_ID_INSTR;
    end
  end

  // mode pins are only observed; a nonzero value is flagged
  assign test_mode_error = test_mode_pin0 | test_mode_pin1;

  // cause flags: power-on wipes others, set wins over a software clear
  assign wr_cause = reg_write && (reg_addr == `RSC_ADDR_CAUSE);
  always @* begin
    next_cause = cause;
    if (done) begin
      if (por_pending) begin
        next_cause = POR_ONLY;
      end else begin
        next_cause = cause | pending;
      end
    end else if (wr_cause) begin
      next_cause = cause & ~reg_wdata[`RSC_CAUSE_W-1:0];
    end
  end
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cause       <= {`RSC_CAUSE_W{1'b0}};
      por_pending <= 1'b1;
    end else begin
      cause <= next_cause;
      if (done) begin
        por_pending <= 1'b0;
      end
    end
  end

  // software-held peripheral resets are dropped by any core reset
  assign wr_periph = reg_write && (reg_addr == `RSC_ADDR_PERIPH);
  assign wr_mask   = reg_write && (reg_addr == `RSC_ADDR_MASK);
  assign wr_ctrl   = reg_write && (reg_addr == `RSC_ADDR_CTRL);
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      periph_sel <= {NUM_PERIPH{1'b0}};
    end else if (sys_rst) begin
      periph_sel <= {NUM_PERIPH{1'b0}};
    end else if (wr_periph) begin
      periph_sel <= reg_wdata[NUM_PERIPH-1:0];
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mask <= {`RSC_CAUSE_W{1'b0}};
    end else if (wr_mask) begin
      mask <= reg_wdata[`RSC_CAUSE_W-1:0];
    end
  end

  // brown-out stays ignored until software enables it
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bor_en <= 1'b0;
    end else if (wr_ctrl) begin
      bor_en <= reg_wdata[`RSC_CTRL_BOR_EN];
    end
  end

  // interrupt status: completed-reset causes, read clears, set wins
  assign rd_status = reg_read && reg_addr == `RSC_ADDR_STATUS;
  wire [`RSC_CAUSE_W-1:0] ev = done ? pending : {`RSC_CAUSE_W{1'b0}};

  always @* begin
    if (rd_status) begin
      next_status = ev;
    end else begin
      next_status = status | ev;
    end
  end
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      status <= {`RSC_CAUSE_W{1'b0}};
    end else begin
      status <= next_status;
    end
  end
  assign irq = |(status & mask);

  // read data stand only in the cycle after the strobe, zero otherwise
  always @* begin
    next_rdata = 32'h0000_0000;
    if (reg_read) begin
      case (reg_addr)
        `RSC_ADDR_CAUSE:  next_rdata = {{(32-`RSC_CAUSE_W){1'b0}}, cause};
        `RSC_ADDR_PERIPH: next_rdata = {{(32-NUM_PERIPH){1'b0}}, periph_sel};
        `RSC_ADDR_MASK:   next_rdata = {{(32-`RSC_CAUSE_W){1'b0}}, mask};
        `RSC_ADDR_STATUS: next_rdata = {{(32-`RSC_CAUSE_W){1'b0}}, status};
        `RSC_ADDR_CTRL:   next_rdata = {31'h0000_0000, bor_en};
        default:          next_rdata = 32'h0000_0000;
      endcase
    end
  end
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule

// *** include/rsc_defs.vh ***
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH
`define RSC_ADDR_CAUSE     4'h0
`define RSC_ADDR_PERIPH    4'h1
`define RSC_ADDR_MASK      4'h2
`define RSC_ADDR_STATUS    4'h3
`define RSC_ADDR_CTRL      4'h4
`define RSC_CAUSE_EXT      0
`define RSC_CAUSE_POR      1
`define RSC_CAUSE_BOR      2
`define RSC_CAUSE_SW       3
`define RSC_CAUSE_WDT      4
`define RSC_CAUSE_W        5
`define RSC_CTRL_BOR_EN    0
`define RSC_STRETCH_CYC    8'h08
`define RSC_ID_INSTR       4'h1
`endif

// *** testbench/rsc_chk.sv ***
`timescale 1ns/1ns
module rsc_chk #(parameter NUM_PERIPH = 8) (
  input wire                  clock,
  input wire                  arst_n,
  input wire                  ext_reset_n,
  input wire                  sw_system_reset_request,
  input wire                  watchdog_reset,
  input wire                  test_reset_n,
  input wire                  test_mode_pin0,
  input wire                  test_mode_pin1,
  input wire                  core_reset_n,
  input wire                  tap_reset_n,
  input wire                  tap_pin_cfg_reset_n,
  input wire [NUM_PERIPH-1:0] periph_reset_n,
  input wire                  fetch_start,
  input wire                  test_mode_error
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence rel_s; $rose(core_reset_n); endsequence
  sequence pulse_s; fetch_start ##1 !fetch_start; endsequence
  tmode_err_a: assert property (test_mode_error == (test_mode_pin0 | test_mode_pin1))
    else $error("test mode error wrong");
  pin_hold_a: assert property (!ext_reset_n |=> !core_reset_n)
    else $error("core left reset while pin low");
  tap_keep_a: assert property (test_reset_n && $past(test_reset_n) && $past(tap_reset_n) |-> tap_reset_n)
    else $error("tap controller reset by wrong source");
  pin_cfg_a: assert property (!ext_reset_n ##1 !ext_reset_n |-> !tap_pin_cfg_reset_n)
    else $error("pin config not reset");
  rel_pulse_a: assert property (rel_s |-> pulse_s)
    else $error("no single fetch pulse at release");
  fetch_rel_a: assert property (fetch_start |-> rel_s)
    else $error("fetch pulse without release");
  src_hold_a: assert property (sw_system_reset_request || watchdog_reset |=> !core_reset_n [*2])
    else $error("core not held by source");
  periph_core_a: assert property (!core_reset_n |-> periph_reset_n == '0)
    else $error("peripheral out of reset with core");
endmodule
bind rsc_reset_control rsc_chk #(.NUM_PERIPH(NUM_PERIPH)) i_chk (.*);

// *** testbench/rsc_board.sv ***
`timescale 1ns/1ns
module rsc_board (
  input  wire       clock,
  input  wire [7:0] hold,
  output wire       ext_reset_n,
  output wire       test_mode_pin0,
  output wire       test_mode_pin1
);
  reg [7:0] left = 8'h00;
  assign test_mode_pin0 = 1'b0;
  assign test_mode_pin1 = 1'b0;
  // switch held for the asked width; pull-up once released
  assign ext_reset_n = (left == 8'h00);
  always @(posedge clock) begin
    if (hold != 8'h00) left <= hold;
    else if (left != 8'h00) left <= left - 8'h01;
  end
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  reg        clock = 1'b0, arst_n = 1'b0, brownout_detect = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  reg        sw_system_reset_request = 1'b0, watchdog_reset = 1'b0, test_reset_n = 1'b1;
  reg        tap_logic_reset_state = 1'b0;
  reg [3:0]  reg_addr = 4'h0;
  reg [7:0]  hold = 8'h00;
  reg [31:0] reg_wdata = 32'h0000_0000, lf = 32'h0b7e_a20b, seen, cz;
  integer    err_count = 0, cmp_count = 0, cyc = 0, i, k;
  wire       ext_reset_n, test_mode_pin0, test_mode_pin1, irq, core_reset_n, tap_reset_n;
  wire       tap_pin_cfg_reset_n, fetch_start, test_mode_error;
  wire [7:0] periph_reset_n;
  wire [31:0] reg_rdata;
  wire [3:0] tap_default_instr;
  rsc_board i_board (.clock, .hold, .ext_reset_n, .test_mode_pin0, .test_mode_pin1);
  rsc_reset_control #(.STRETCH(2)) i_dut (.clock, .arst_n, .ext_reset_n, .brownout_detect,
    .sw_system_reset_request, .watchdog_reset, .test_reset_n, .tap_logic_reset_state, .test_mode_pin0,
    .test_mode_pin1, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq, .core_reset_n,
    .tap_reset_n, .tap_pin_cfg_reset_n, .periph_reset_n, .fetch_start, .tap_default_instr, .test_mode_error);
  initial forever #5 clock = ~clock;
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task report_and_stop; begin
    $display("mismatches %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end endtask
  task chk(input [31:0] s, input [31:0] e); begin
    cmp_count = cmp_count + 1;
    if (s !== e) begin
      err_count = err_count + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  end endtask
  task wreg(input [3:0] a, input [31:0] d); begin
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  end endtask
  task rreg(input [3:0] a); begin
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    seen = reg_rdata;
  end endtask
  // bits: 0 pin, 2 brownout, 3 software, 4 watchdog; pin width random, never below 3
  task fire(input [4:0] s); begin
    if (s[2]) wreg(4'h4, 32'h0000_0001);
    lf = lfsr(lf);
    @(posedge clock);
    hold <= s[0] ? {4'h0, lf[3:0]} + 8'h03 : 8'h00;
    {watchdog_reset, sw_system_reset_request, brownout_detect} <= s[4:2];
    repeat (2) @(posedge clock);
    {hold, watchdog_reset, sw_system_reset_request, brownout_detect} <= 11'h000;
    @(negedge clock);
    if (s != 5'h00) chk({core_reset_n, tap_reset_n}, 2'b01);
    for (i = 0; i < 200 && core_reset_n !== 1'b1; i = i + 1) @(negedge clock);
    chk(fetch_start, 1'b1);
    cz = cz | s;
    rreg(4'h0);
    chk(seen, cz);
  end endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      report_and_stop;
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    cz = 32'h0000_0002;
    fire(5'h00);
    chk({tap_reset_n, tap_default_instr, test_mode_error}, 6'h22);
    for (k = 0; k < 6; k = k + 1) fire(k[0] ? 5'h19 : (lf[4:0] & 5'h1d) | 5'h08);
    wreg(4'h0, 32'h0000_001f);
    rreg(4'h0);
    chk(seen, 32'h0000_0000);
    cz = 0;
    rreg(4'h3);
    wreg(4'h2, 32'h0000_0000);
    fire(5'h10);
    chk(irq, 1'b0);
    wreg(4'h2, 32'h0000_001f);
    @(negedge clock);
    chk(irq, 1'b1);
    rreg(4'h3);
    chk(seen, 32'h0000_0010);
    chk(irq, 1'b0);
    wreg(4'h1, {24'h0, lf[7:0]});
    @(negedge clock);
    chk({core_reset_n, periph_reset_n}, {1'b1, ~lf[7:0]});
    fire(5'h08);
    chk(periph_reset_n, 8'hff);
    rreg(4'hf);
    chk(seen, 32'h0000_0000);
    @(posedge clock);
    test_reset_n <= 1'b0;
    tap_logic_reset_state <= 1'b1;
    @(negedge clock);
    chk({tap_reset_n, core_reset_n}, 2'b01);
    @(posedge clock);
    test_reset_n <= 1'b1;
    tap_logic_reset_state <= 1'b0;
    repeat (4) @(negedge clock);
    chk({tap_reset_n, tap_default_instr}, 5'h11);
    report_and_stop;
  end
endmodule
